// File: hdl/asfr_alu_flags.sv
// Eight-bit ALU with overflow, zero, nibble-carry and carry generation.
`timescale 1ns/1ps
`default_nettype none
module asfr_alu_flags
(
  asfr_alu_if.alu aluPort
);
  import asfr_pkg::*;

  // Adder shared by add, subtract, increment and decrement
  // Returns {carry, nibbleCarry, overflow, sum}
  function automatic logic [10:0] addFlags(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    logic ov;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    ov = (a[7] == b[7]) && (full[7] != a[7]);
    return {full[8], lo[4], ov, full[7:0]};
  endfunction

  logic [10:0] sumBits; // Adder output for this operation
  logic [7:0] res; // Result before the zero test
  logic carryOut; // Carry produced by a rotate

  // Operation decode; flags not in the mask are ignored by the core
  always_comb
  begin
    sumBits = addFlags(aluPort.opA, aluPort.opB, 1'b0);
    res = aluPort.opA;
    carryOut = aluPort.carryIn;
    aluPort.mask = MASK_NONE;
    case (aluPort.op)
      OP_ADD_ACC_FILE, OP_ADD_LITERAL:
      begin
        aluPort.mask = MASK_ALL;
        res = sumBits[7:0];
      end
      OP_SUB_ACC_FILE, OP_SUB_LITERAL:
      begin
        // Carry set means no borrow, by the two's complement add
        sumBits = addFlags(aluPort.opA, ~aluPort.opB, 1'b1);
        aluPort.mask = MASK_ALL;
        res = sumBits[7:0];
      end
      OP_INC:
      begin
        sumBits = addFlags(aluPort.opA, 8'h01, 1'b0);
        aluPort.mask = MASK_ALL;
        res = sumBits[7:0];
      end
      OP_DEC:
      begin
        sumBits = addFlags(aluPort.opA, 8'hFF, 1'b0);
        aluPort.mask = MASK_ALL;
        res = sumBits[7:0];
      end
      OP_AND_FILE, OP_AND_LITERAL:
      begin
        aluPort.mask = MASK_ZERO;
        res = aluPort.opA & aluPort.opB;
      end
      OP_OR_FILE:
      begin
        aluPort.mask = MASK_ZERO;
        res = aluPort.opA | aluPort.opB;
      end
      OP_XOR_FILE:
      begin
        aluPort.mask = MASK_ZERO;
        res = aluPort.opA ^ aluPort.opB;
      end
      OP_COMPLEMENT:
      begin
        aluPort.mask = MASK_ZERO;
        res = ~aluPort.opA;
      end
      OP_ROT_RIGHT_THROUGH:
      begin
        aluPort.mask = MASK_CARRY;
        res = {aluPort.carryIn, aluPort.opA[7:1]};
        carryOut = aluPort.opA[0];
      end
      OP_ROT_LEFT_THROUGH:
      begin
        aluPort.mask = MASK_CARRY;
        res = {aluPort.opA[6:0], aluPort.carryIn};
        carryOut = aluPort.opA[7];
      end
      OP_CLEAR_FILE:
      begin
        aluPort.mask = MASK_ZERO;
        res = 8'h00;
      end
      // Bit, swap and move operations write no flags unless the status byte is their destination
      OP_BIT_CLEAR: res = aluPort.opA & ~(8'h01 << aluPort.bitSel);
      OP_BIT_SET: res = aluPort.opA | (8'h01 << aluPort.bitSel);
      OP_NIBBLE_SWAP: res = {aluPort.opA[3:0], aluPort.opA[7:4]};
      OP_MOVE_FROM_ACC: res = aluPort.opB;
      default: res = aluPort.opA;
    endcase
  end

  // Rotates report their own carry; arithmetic uses the adder
  assign aluPort.result = res;
  assign aluPort.flags = {sumBits[8], res == 8'h00, sumBits[9],
                          (aluPort.mask == MASK_CARRY) ? carryOut : sumBits[10]};
  // Multiply is unsigned and never writes flags
  assign aluPort.product = aluPort.opA * aluPort.opB;
endmodule
`default_nettype wire

// File: hdl/asfr_alu_if.sv
// Carrier between the status register core and its flag-generating ALU.
`timescale 1ns/1ps
`default_nettype none
interface asfr_alu_if;
  import asfr_pkg::*;
  asfr_op_t op; // Operation to perform
  logic [7:0] opA; // File, literal or single operand
  logic [7:0] opB; // Accumulator operand
  logic [2:0] bitSel; // Bit number for bit set or clear
  logic carryIn; // Current carry flag
  logic [7:0] result; // Eight-bit result
  logic [15:0] product; // Multiply result
  logic [3:0] flags; // OV, Z, DC, C from the flag logic
  logic [3:0] mask; // Flags this operation writes

  modport alu (input op, opA, opB, bitSel, carryIn, output result, product, flags, mask);
  modport core (output op, opA, opB, bitSel, carryIn, input result, product, flags, mask);
endinterface
`default_nettype wire

// File: hdl/asfr_pkg.sv
// Constants, opcodes and step codes for the ALU status and pointer mode register.
// Summary of operation
// - Status register accepts every instruction as destination.
// - Flag-updating writes take flags from flag logic.
// - Clear-file zeroes mode bits, sets zero flag.
// - Bit, swap, move-from-acc instructions keep flags unless the status register is the destination.
// - Bits 7:6 step pointer 1 after access.
// - Bits 5:4 step pointer 0 after access.
// - Bit 3 flags signed range overflow.
// - Bit 2 set when result is zero.
// - Bit 1 is carry out of bit 3.
// - Bit 0 is carry out of bit 7.
// - Subtract adds two's complement; carry means no borrow.
// - Rotate through carry loads shifted-out bit.
// - Single operand from accumulator or file register.
// - Two operands: accumulator with file or literal.
// - Status register sits at unbanked address 04h.
// - Multiply leaves all four flags unchanged.
package asfr_pkg;

  // Address of the status register, seen from every bank
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  // Mode bits come up as ones, flag bits as zero
  localparam logic [7:0] STATUS_RESET = 8'hF0;
  // Bit positions inside the status byte
  localparam int BIT_OV = 3;
  localparam int BIT_Z = 2;
  localparam int BIT_DC = 1;
  localparam int BIT_C = 0;
  localparam int PTR1_LO = 6;
  localparam int PTR0_LO = 4;
  // Which of the four flags an operation writes (OV, Z, DC, C)
  localparam logic [3:0] MASK_ALL = 4'hF;
  localparam logic [3:0] MASK_ZERO = 4'h4;
  localparam logic [3:0] MASK_CARRY = 4'h1;
  localparam logic [3:0] MASK_NONE = 4'h0;
  // Mode field encodings
  localparam logic [1:0] STEP_DEC_CODE = 2'h0;
  localparam logic [1:0] STEP_INC_CODE = 2'h1;
  // Bus read value for unmapped addresses
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Operations issued by the instruction execution logic
  typedef enum logic [4:0] {
    OP_NOP,
    OP_ADD_ACC_FILE,
    OP_ADD_LITERAL,
    OP_SUB_ACC_FILE,
    OP_SUB_LITERAL,
    OP_AND_FILE,
    OP_AND_LITERAL,
    OP_OR_FILE,
    OP_XOR_FILE,
    OP_INC,
    OP_DEC,
    OP_COMPLEMENT,
    OP_ROT_RIGHT_THROUGH,
    OP_ROT_LEFT_THROUGH,
    OP_CLEAR_FILE,
    OP_BIT_CLEAR,
    OP_BIT_SET,
    OP_NIBBLE_SWAP,
    OP_MOVE_FROM_ACC,
    OP_MOVE_FILE,
    OP_MUL_FILE,
    OP_MUL_LITERAL
  } asfr_op_t;

  // Post-access action on an indirect pointer
  typedef enum logic [1:0] {
    STEP_DECREMENT,
    STEP_INCREMENT,
    STEP_HOLD
  } asfr_step_t;

endpackage

// File: hdl/asfr_ptr_step.sv
// Decodes a two-bit pointer mode field into the post-access step.
`timescale 1ns/1ps
`default_nettype none
module asfr_ptr_step
(
  input wire logic [1:0] modeField,
  output asfr_pkg::asfr_step_t step
);
  import asfr_pkg::*;

  // Both codes with the high bit set mean hold
  always_comb
  begin
    case (modeField)
      STEP_DEC_CODE: step = STEP_DECREMENT;
      STEP_INC_CODE: step = STEP_INCREMENT;
      default: step = STEP_HOLD;
    endcase
  end
endmodule
`default_nettype wire

// File: hdl/asfr_status_top.sv
// ALU status and pointer mode register with operand routing and write-back.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module asfr_status_top
(
  input wire logic clk,
  input wire logic rst,
  // Software register port
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWrEn,
  input wire logic busRdEn,
  output logic [7:0] busRdData,
  // Instruction issue from the execution logic
  input wire logic instrValid,
  input wire asfr_pkg::asfr_op_t instrOp,
  input wire logic [7:0] instrFileAddr,
  input wire logic instrDestFile,
  input wire logic instrSrcFile,
  input wire logic [7:0] instrLiteral,
  input wire logic [2:0] instrBitSel,
  input wire logic [7:0] accData,
  input wire logic [7:0] fileData,
  // Write-back toward accumulator and file registers
  output logic [7:0] resultData,
  output logic accWrEn,
  output logic fileWrEn,
  output logic [7:0] fileWrAddr,
  output logic [15:0] productData,
  output logic productWrEn,
  // Status and mode view
  output logic [7:0] statusData,
  output logic signedRangeFlag,
  output logic zeroFlag,
  output logic nibbleCarryFlag,
  output logic carryFlag,
  output asfr_pkg::asfr_step_t pointer1Step,
  output asfr_pkg::asfr_step_t pointer0Step
);
  import asfr_pkg::*;

  // Status byte and its next value
  logic [7:0] status_reg;
  logic [7:0] status_next;
  // Registered bus read data
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  // Write-back registers
  logic [7:0] result_reg;
  logic accWr_reg;
  logic fileWr_reg;
  logic [7:0] fileAddr_reg;
  logic [15:0] product_reg;
  logic productWr_reg;

  // Decoded instruction attributes
  logic hitsStatus; // Instruction addresses the status register
  logic [7:0] fileOperand; // File operand, status served locally
  logic usesLiteral; // Second operand is the immediate
  logic singleOperand; // Operand may be accumulator or file
  logic forcedFile; // Destination is always the file
  logic toFile; // Result goes to a file register
  logic toAcc; // Result goes to the accumulator
  logic isMultiply; // Result goes to the product only
  logic isNop; // Nothing is written
  logic [3:0] mergedFlags; // Flags after masking in new values

  asfr_alu_if aluBus ();

  // Flag-producing ALU
  asfr_alu_flags aluUnit
  (
    .aluPort(aluBus.alu)
  );

  // Pointer 1 mode decode from bits 7:6
  asfr_ptr_step ptr1Decode
  (
    .modeField(status_reg[PTR1_LO +: 2]),
    .step(pointer1Step)
  );

  // Pointer 0 mode decode from bits 5:4
  asfr_ptr_step ptr0Decode
  (
    .modeField(status_reg[PTR0_LO +: 2]),
    .step(pointer0Step)
  );

  // Address match ignores banking since the register is unbanked
  function automatic logic isStatusAddr(input logic [7:0] addr);
    return addr == STATUS_ADDR;
  endfunction

  // Classify the operation for operand and destination routing
  always_comb
  begin
    usesLiteral = 1'b0;
    singleOperand = 1'b0;
    forcedFile = 1'b0;
    isMultiply = 1'b0;
    isNop = 1'b0;
    case (instrOp)
      OP_ADD_LITERAL, OP_SUB_LITERAL, OP_AND_LITERAL: usesLiteral = 1'b1;
      OP_MUL_LITERAL:
      begin
        usesLiteral = 1'b1;
        isMultiply = 1'b1;
      end
      OP_MUL_FILE: isMultiply = 1'b1;
      OP_INC, OP_DEC, OP_COMPLEMENT, OP_ROT_RIGHT_THROUGH,
      OP_ROT_LEFT_THROUGH, OP_NIBBLE_SWAP, OP_MOVE_FILE: singleOperand = 1'b1;
      OP_CLEAR_FILE, OP_BIT_CLEAR, OP_BIT_SET, OP_MOVE_FROM_ACC: forcedFile = 1'b1;
      OP_NOP: isNop = 1'b1;
      default: isNop = 1'b0;
    endcase
  end

  // Read-modify-write of the status must see the live byte, not a stale copy
  assign hitsStatus = isStatusAddr(instrFileAddr);
  assign fileOperand = hitsStatus ? status_reg : fileData;

  // Operand selection feeding the ALU
  always_comb
  begin
    aluBus.op = instrOp;
    aluBus.opB = accData;
    aluBus.bitSel = instrBitSel;
    aluBus.carryIn = status_reg[BIT_C];
    if (singleOperand)
    begin
      // Single operand from file or accumulator
      aluBus.opA = instrSrcFile ? fileOperand : accData;
    end
    else if (usesLiteral)
    begin
      aluBus.opA = instrLiteral;
    end
    else
    begin
      aluBus.opA = fileOperand;
    end
  end

  // Destination choice; literal ops other than multiply always land in the accumulator
  assign toFile = !isNop && !isMultiply && !usesLiteral && (forcedFile || instrDestFile);
  assign toAcc = !isNop && !isMultiply && !toFile;

  // Only flags the operation affects are replaced
  assign mergedFlags = (aluBus.flags & aluBus.mask) | (status_reg[3:0] & ~aluBus.mask);

  // Next status value: instruction has priority over a bus write
  always_comb
  begin
    status_next = status_reg;
    if (instrValid)
    begin
      if (toFile && hitsStatus)
      begin
        // Status accepts any instruction as destination
        if (aluBus.mask != MASK_NONE)
        begin
          // Flag write from the data path is disabled, flag logic wins
          status_next = {aluBus.result[7:4], mergedFlags};
        end
        else
        begin
          // Flag-neutral instructions write the whole byte
          status_next = aluBus.result;
        end
      end
      else
      begin
        // Mode bits stay; multiply has an empty mask and keeps flags
        status_next = {status_reg[7:4], mergedFlags};
      end
    end
    else if (busWrEn && isStatusAddr(busAddr))
    begin
      status_next = busWrData;
    end
  end

  // Status register, updated in the instruction's own cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_reg <= STATUS_RESET;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // Bus read data, one cycle after the strobe and only then
  always_comb
  begin
    rdData_next = READ_IDLE;
    if (busRdEn && isStatusAddr(busAddr))
    begin
      rdData_next = status_reg;
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdData_reg <= READ_IDLE;
    end
    else
    begin
      rdData_reg <= rdData_next;
    end
  end

  // Result write-back, same edge as the flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result_reg <= 8'h00;
      accWr_reg <= 1'b0;
      fileWr_reg <= 1'b0;
      fileAddr_reg <= 8'h00;
    end
    else
    begin
      accWr_reg <= instrValid && toAcc;
      // The status byte lives here, so no external write for it
      fileWr_reg <= instrValid && toFile && !hitsStatus;
      if (instrValid)
      begin
        result_reg <= aluBus.result;
        fileAddr_reg <= instrFileAddr;
      end
    end
  end

  // Product write-back for multiply
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      product_reg <= 16'h0000;
      productWr_reg <= 1'b0;
    end
    else
    begin
      productWr_reg <= instrValid && isMultiply;
      if (instrValid && isMultiply)
      begin
        product_reg <= aluBus.product;
      end
    end
  end

  // Outputs straight from registers
  assign busRdData = rdData_reg;
  assign resultData = result_reg;
  assign accWrEn = accWr_reg;
  assign fileWrEn = fileWr_reg;
  assign fileWrAddr = fileAddr_reg;
  assign productData = product_reg;
  assign productWrEn = productWr_reg;
  assign statusData = status_reg;
  assign signedRangeFlag = status_reg[BIT_OV];
  assign zeroFlag = status_reg[BIT_Z];
  assign nibbleCarryFlag = status_reg[BIT_DC];
  assign carryFlag = status_reg[BIT_C];
endmodule
`default_nettype wire

// File: sim/asfr_exec_model.sv
// Behavioural model of the instruction execution side: accumulator and file registers.
`timescale 1ns/1ps
`default_nettype none
module asfr_exec_model
(
  input wire logic clk,
  input wire logic [7:0] instrFileAddr,
  input wire logic [7:0] resultData,
  input wire logic accWrEn,
  input wire logic fileWrEn,
  input wire logic [7:0] fileWrAddr,
  output logic [7:0] accData,
  output logic [7:0] fileData
);
  logic [7:0] accReg; // Working accumulator
  logic [7:0] fileMem [256]; // File registers; the status byte lives in the core, not in this block

  // Write-back lands at the next edge
  always @(posedge clk)
  begin
    if (accWrEn)
      accReg <= resultData;
    if (fileWrEn)
      fileMem[fileWrAddr] <= resultData;
  end

  // Bypass, so a back-to-back instruction sees the fresh result
  assign accData = accWrEn ? resultData : accReg;
  assign fileData = (fileWrEn && fileWrAddr == instrFileAddr) ? resultData
                    : fileMem[instrFileAddr];

  // Bench loads the accumulator only in a cycle without write-back
  task setAcc(input logic [7:0] v);
    accReg = v;
  endtask
endmodule
`default_nettype wire

// File: sim/asfr_status_top_chk.sv
// Port-level assertions for the status and pointer mode register.
`timescale 1ns/1ps
`default_nettype none
module asfr_status_chk
  import asfr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWrEn,
  input wire logic busRdEn,
  input wire logic [7:0] busRdData,
  input wire logic instrValid,
  input wire asfr_op_t instrOp,
  input wire logic [7:0] instrFileAddr,
  input wire logic instrSrcFile,
  input wire logic [7:0] instrLiteral,
  input wire logic [7:0] accData,
  input wire logic [7:0] resultData,
  input wire logic accWrEn,
  input wire logic fileWrEn,
  input wire logic productWrEn,
  input wire logic [7:0] statusData,
  input wire logic zeroFlag,
  input wire logic nibbleCarryFlag,
  input wire logic carryFlag,
  input wire asfr_step_t pointer1Step
);
  logic [8:0] sumLit; // Full add of accumulator and literal
  logic [4:0] nibLit; // Low nibble add
  assign sumLit = 9'(accData) + 9'(instrLiteral);
  assign nibLit = 5'(accData[3:0]) + 5'(instrLiteral[3:0]);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // An instruction of the given kind is taken
  sequence sIssue(o);
    instrValid && instrOp == o;
  endsequence

  AST_PTR1_DECODE: assert property (pointer1Step == (statusData[7] ? STEP_HOLD :
    statusData[6] ? STEP_INCREMENT : STEP_DECREMENT)) else $error("pointer1 step wrong");
  AST_ZERO_RESULT: assert property (instrValid && instrOp inside {OP_ADD_LITERAL,
    OP_SUB_LITERAL, OP_AND_LITERAL} |=> zeroFlag == (resultData == 8'h00))
    else $error("zero flag wrong");
  AST_ADD_CARRY: assert property (sIssue(OP_ADD_LITERAL) |=> carryFlag == $past(sumLit[8])
    && nibbleCarryFlag == $past(nibLit[4])) else $error("add carry wrong");
  AST_SUB_BORROW: assert property (sIssue(OP_SUB_LITERAL) |=>
    carryFlag == ($past(instrLiteral) >= $past(accData))) else $error("borrow wrong");
  AST_ROT_CARRY: assert property ((sIssue(OP_ROT_RIGHT_THROUGH) ##0 !instrSrcFile) |=>
    carryFlag == $past(accData[0])) else $error("rotate carry wrong");
  AST_NEUTRAL_KEEPS: assert property (instrValid && instrFileAddr != STATUS_ADDR &&
    instrOp inside {OP_BIT_SET, OP_BIT_CLEAR, OP_NIBBLE_SWAP, OP_MOVE_FROM_ACC,
    OP_MUL_LITERAL, OP_MUL_FILE} |=> $stable(statusData)) else $error("flags moved");
  AST_CLEAR_STATUS: assert property ((sIssue(OP_CLEAR_FILE) ##0
    instrFileAddr == STATUS_ADDR) |=> statusData == ({4'h0, $past(statusData[3:0])} | 8'h04))
    else $error("clear of status wrong");
  AST_READ_STATUS: assert property (busRdEn && busAddr == STATUS_ADDR |=>
    busRdData == $past(statusData)) else $error("status read wrong");
  AST_UNMAPPED: assert property (busRdEn && busAddr != STATUS_ADDR |=>
    busRdData == READ_IDLE) else $error("unmapped read wrong");
  AST_BUS_WRITE: assert property (busWrEn && busAddr == STATUS_ADDR && !instrValid |=>
    statusData == $past(busWrData)) else $error("status write lost");
  AST_IDLE_NO_WB: assert property (!instrValid |=> !accWrEn && !fileWrEn && !productWrEn)
    else $error("stray write-back");
  AST_LIT_WB: assert property (sIssue(OP_ADD_LITERAL) |=> accWrEn && !fileWrEn)
    else $error("literal result misrouted");
endmodule
`default_nettype wire

// File: sim/tb_alu_status_flag_register.sv
// Self-checking bench for the status and pointer mode register.
`timescale 1ns/1ps
`default_nettype none
module tb_alu_status_flag_register;
  import asfr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] busAddr = 8'h00;
  logic [7:0] busWrData = 8'h00;
  logic busWrEn = 1'b0;
  logic busRdEn = 1'b0;
  logic instrValid = 1'b0;
  asfr_op_t instrOp = OP_NOP;
  logic [7:0] instrFileAddr = 8'h00;
  logic instrDestFile = 1'b0;
  logic instrSrcFile = 1'b0;
  logic [7:0] instrLiteral = 8'h00;
  logic [2:0] instrBitSel = 3'h0;
  logic [7:0] accData, fileData, busRdData, resultData, fileWrAddr, statusData;
  logic [15:0] productData;
  logic accWrEn, fileWrEn, productWrEn, carryFlag, ovFlag;
  asfr_step_t pointer1Step, pointer0Step;
  int num_errors = 0;
  int num_checks = 0;

  // Free-running 40 MHz clock
  always #12.5 clk = ~clk;

  asfr_status_top i_asfr_status_top (.clk, .rst, .busAddr, .busWrData, .busWrEn, .busRdEn,
    .busRdData, .instrValid, .instrOp, .instrFileAddr, .instrDestFile, .instrSrcFile,
    .instrLiteral, .instrBitSel, .accData, .fileData, .resultData, .accWrEn, .fileWrEn,
    .fileWrAddr, .productData, .productWrEn, .statusData, .signedRangeFlag(ovFlag), .zeroFlag(),
    .nibbleCarryFlag(), .carryFlag, .pointer1Step, .pointer0Step);
  asfr_exec_model i_asfr_exec_model (.clk, .instrFileAddr, .resultData, .accWrEn,
    .fileWrEn, .fileWrAddr, .accData, .fileData);

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bus and issue tasks start just after an edge; latency is fixed at one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busWrEn <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge clk);
    busWrEn <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    busRdEn <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRdEn <= 1'b0;
    #1;
    chk(busRdData, exp);
  endtask

  // Literal low bits double as the bit number for bit operations
  task automatic ins(input asfr_op_t o, input logic [7:0] fa, input logic d, input logic s,
                     input logic [7:0] l);
    instrValid <= 1'b1;
    instrOp <= o;
    instrFileAddr <= fa;
    instrDestFile <= d;
    instrSrcFile <= s;
    instrLiteral <= l;
    instrBitSel <= l[2:0];
    @(posedge clk);
    instrValid <= 1'b0;
    #1;
  endtask

  // Idle cycle first, so no pending write-back overwrites the loaded value
  task automatic acc(input logic [7:0] v);
    @(posedge clk);
    #1;
    i_asfr_exec_model.setAcc(v);
  endtask

  // Reference add: result, then OV, Z, DC, C
  function automatic logic [11:0] addf(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = 9'(a) + 9'(b) + 9'(ci);
    h = 5'(a[3:0]) + 5'(b[3:0]) + 5'(ci);
    return {s[7:0], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  task automatic t_regs;
    logic [7:0] e;
    rd(STATUS_ADDR, STATUS_RESET);
    rd(8'h05, READ_IDLE);
    for (int c = 0; c < 4; c++)
    begin
      wr(STATUS_ADDR, {c[1:0], c[1:0], 4'h5});
      e = c == 0 ? 8'(STEP_DECREMENT) : c == 1 ? 8'(STEP_INCREMENT) : 8'(STEP_HOLD);
      chk(8'(pointer1Step), e);
      chk(8'(pointer0Step), e);
      rd(STATUS_ADDR, {c[1:0], c[1:0], 4'h5});
    end
  endtask

  task automatic t_arith;
    logic [7:0] a [4] = '{8'h80, 8'h0F, 8'h7F, 8'h3C};
    logic [7:0] b [4] = '{8'h80, 8'h01, 8'h01, 8'h3C};
    logic [11:0] e;
    for (int i = 0; i < 4; i++)
    begin
      acc(a[i]);
      ins(OP_ADD_LITERAL, 8'h00, 1'b0, 1'b0, b[i]);
      e = addf(a[i], b[i], 1'b0);
      chk(resultData, e[11:4]);
      chk({4'h0, statusData[3:0]}, {4'h0, e[3:0]});
      chk({7'h0, accWrEn}, 8'h01);
      chk({7'h0, ovFlag}, {7'h0, e[3]});
      acc(a[i]);
      ins(OP_SUB_LITERAL, 8'h00, 1'b0, 1'b0, b[i]);
      e = addf(b[i], ~a[i], 1'b1);
      chk(resultData, e[11:4]);
      chk({4'h0, statusData[3:0]}, {4'h0, e[3:0]});
    end
  endtask

  // File operands, then the status byte as destination
  task automatic t_file;
    acc(8'h5A);
    ins(OP_MOVE_FROM_ACC, 8'h20, 1'b1, 1'b0, 8'h00);
    chk(fileWrAddr, 8'h20);
    ins(OP_ADD_ACC_FILE, 8'h20, 1'b0, 1'b1, 8'h00);
    chk(resultData, 8'hB4);
    chk({4'h0, statusData[3:0]}, 8'h0A);
    ins(OP_COMPLEMENT, 8'h20, 1'b0, 1'b1, 8'h00);
    chk(resultData, 8'hA5);
    wr(STATUS_ADDR, 8'h5A);
    ins(OP_CLEAR_FILE, STATUS_ADDR, 1'b1, 1'b0, 8'h00);
    chk(statusData, 8'h0E);
    ins(OP_BIT_SET, STATUS_ADDR, 1'b1, 1'b0, 8'h07);
    chk(statusData, 8'h8E);
    acc(8'h33);
    ins(OP_MOVE_FROM_ACC, STATUS_ADDR, 1'b1, 1'b0, 8'h00);
    chk(statusData, 8'h33);
    acc(8'h01);
    ins(OP_ADD_ACC_FILE, STATUS_ADDR, 1'b1, 1'b1, 8'h00);
    chk(statusData, 8'h30);
    ins(OP_NIBBLE_SWAP, STATUS_ADDR, 1'b1, 1'b1, 8'h00);
    chk(statusData, 8'h03);
    ins(OP_BIT_CLEAR, STATUS_ADDR, 1'b1, 1'b0, 8'h00);
    chk(statusData, 8'h02);
    acc(8'h10);
    ins(OP_MUL_LITERAL, 8'h00, 1'b0, 1'b0, 8'h20);
    chk(productData[15:8], 8'h02);
    chk(statusData, 8'h02);
  endtask

  // Back-to-back rotates: the second sees the first one's carry
  task automatic t_rot;
    acc(8'h81);
    ins(OP_ROT_RIGHT_THROUGH, 8'h00, 1'b0, 1'b0, 8'h00);
    chk(resultData, 8'h40);
    chk({7'h0, carryFlag}, 8'h01);
    ins(OP_ROT_LEFT_THROUGH, 8'h00, 1'b0, 1'b0, 8'h00);
    chk(resultData, 8'h81);
    chk({7'h0, carryFlag}, 8'h00);
  endtask

  // Decrement and increment back to back, then logic, file subtract and file multiply back to back
  task automatic t_misc;
    acc(8'h01);
    ins(OP_DEC, 8'h00, 1'b0, 1'b0, 8'h00);
    chk(resultData, 8'h00);
    chk({4'h0, statusData[3:0]}, 8'h07);
    ins(OP_INC, 8'h00, 1'b0, 1'b0, 8'h00);
    chk(resultData, 8'h01);
    chk({4'h0, statusData[3:0]}, 8'h00);
    acc(8'h5A);
    ins(OP_XOR_FILE, 8'h20, 1'b0, 1'b0, 8'h00);
    chk({4'h0, statusData[3:0]}, 8'h04);
    ins(OP_SUB_ACC_FILE, 8'h20, 1'b0, 1'b1, 8'h00);
    chk(resultData, 8'h5A);
    chk({4'h0, statusData[3:0]}, 8'h03);
    ins(OP_MUL_FILE, 8'h20, 1'b0, 1'b1, 8'h00);
    chk(productData[15:8], 8'h1F);
    chk(productData[7:0], 8'hA4);
    chk({4'h0, statusData[3:0]}, 8'h03);
  endtask

  // Reset for four cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_regs();
    t_arith();
    t_file();
    t_rot();
    t_misc();
    tally_and_finish();
  end
endmodule

bind asfr_status_top asfr_status_chk i_asfr_status_chk (.clk, .rst, .busAddr, .busWrData,
  .busWrEn, .busRdEn, .busRdData, .instrValid, .instrOp, .instrFileAddr, .instrSrcFile,
  .instrLiteral, .accData, .resultData, .accWrEn, .fileWrEn, .productWrEn, .statusData,
  .zeroFlag, .nibbleCarryFlag, .carryFlag, .pointer1Step);
`default_nettype wire
